// ### hdl/bpcr_regs.v
// Boost and PWM configuration register bank with its decoded controls
//
// Function
// - Bit 6 clear adjusts boost every PWM cycle; set adjusts every sixteenth.
// - Bit 7 selects normal adaptive control or light-load droop-limiting control.
// - Boost bit 5 enables the eye-smoothed brightness ramp.
// - Bit 4 picks internal switch or external switch via the gate-drive pin.
// - Bit 3 clear holds fixed boost level; set tracks LED voltage plus headroom.
// - Bit 2 clear keeps boost off; set turns it on with backlight.
// - Bits 1:0 choose current limit 0.9, 1.4, 2.0 or 2.5 amperes.
// - PWM register bit 5 picks normal or phase-shifted output PWM.
// - Three-bit headroom field sets 125 mV steps, 125 to 1000 mV.
//
// Implementation choice: the plain strobed port.
`include "bpcr_consts.vh"
module bpcr_regs (
	input wire ref_clk_in,
	input wire srst_in,
	input wire [7:0] addr_in,
	input wire [7:0] wdata_in,
	input wire wr_in,
	input wire rd_in,
	output reg [7:0] rdata_out,
	input wire backlight_on_in,
	input wire pwm_cycle_in,
	output wire boost_adjust_out,
	output wire light_load_mode_out,
	output wire smooth_ramp_enable_out,
	output wire outer_switch_select_out,
	output wire gate_drive_enable_out,
	output wire adaptive_track_out,
	output wire boost_run_out,
	output wire [1:0] inductor_current_limit_out,
	output reg [11:0] current_limit_ma_out,
	output wire [1:0] low_supply_threshold_out,
	output wire staggered_pwm_enable_out,
	output wire [4:0] output_rate_code_out,
	output wire [2:0] sink_headroom_setting_out,
	output reg [11:0] headroom_mv_out
);
	wire [7:0] boost_q;
	wire [7:0] pwm_q;
	wire [7:0] headroom_q;
	wire [3:0] cycle_cnt;
	reg [7:0] rdata_d;
	reg [11:0] limit_ma_d;
	reg [11:0] headroom_mv_d;
	wire slow_adj;
	wire pace_take;
	wire [1:0] limit_code;
	wire [2:0] headroom_code;
	wire [7:0] status_byte;
	wire wr_boost;
	wire wr_pwm;
	wire wr_headroom;

	// Write decode; the status address has no store, so writes there are dropped
	assign wr_boost = wr_in & (addr_in == `BPCR_OFS_BOOST);
	assign wr_pwm = wr_in & (addr_in == `BPCR_OFS_PWM);
	assign wr_headroom = wr_in & (addr_in == `BPCR_OFS_HEADROOM);

	// Status shows the live run state and pacing count
	assign status_byte = {3'b000, boost_run_out, cycle_cnt};

	// Whole bytes stored; reserved encodings kept as written
	// boost byte store
	bpcr_byte_reg #(
		.RST_VAL(`BPCR_RST_BOOST)
	) u_boost_byte (
		.clk_in(ref_clk_in),
		.srst_in(srst_in),
		.wr_in(wr_boost),
		.wdata_in(wdata_in),
		.value_out(boost_q)
	);

	bpcr_byte_reg #(
		.RST_VAL(`BPCR_RST_PWM)
	) u_pwm_byte (
		.clk_in(ref_clk_in),
		.srst_in(srst_in),
		.wr_in(wr_pwm),
		.wdata_in(wdata_in),
		.value_out(pwm_q)
	);

	bpcr_byte_reg #(
		.RST_VAL(`BPCR_RST_HEADROOM)
	) u_headroom_byte (
		.clk_in(ref_clk_in),
		.srst_in(srst_in),
		.wr_in(wr_headroom),
		.wdata_in(wdata_in),
		.value_out(headroom_q)
	);

	// Unmapped addresses read zero; status shows the live run state and pacing count
	always @* begin
		rdata_d = 8'h00;
		if (rd_in) begin
			case (addr_in)
				`BPCR_OFS_BOOST: begin
					rdata_d = boost_q;
				end
				`BPCR_OFS_PWM: begin
					rdata_d = pwm_q;
				end
				`BPCR_OFS_HEADROOM: begin
					rdata_d = headroom_q;
				end
				`BPCR_OFS_STATUS: begin
					rdata_d = status_byte;
				end
				default: begin
					rdata_d = 8'h00;
				end
			endcase
		end
	end

	always @(posedge ref_clk_in) begin
		if (srst_in) begin
			rdata_out <= 8'h00;
		end else begin
			rdata_out <= rdata_d;
		end
	end

	assign slow_adj = boost_q[`BPCR_BIT_SLOW_ADJ];
	// Pulses are only taken while boost runs in adaptive mode; otherwise the count holds
	assign pace_take = pwm_cycle_in & boost_run_out & adaptive_track_out;

	bpcr_pace_div #(
		.CNT_W(4),
		.LAST(`BPCR_SLOW_DIV)
	) u_pace_div (
		.clk_in(ref_clk_in),
		.srst_in(srst_in),
		.take_in(pace_take),
		.slow_in(slow_adj),
		.count_out(cycle_cnt),
		.fire_out(boost_adjust_out)
	);

	assign light_load_mode_out = boost_q[`BPCR_BIT_LIGHT_LOAD];
	assign smooth_ramp_enable_out = boost_q[`BPCR_BIT_SMOOTH];
	assign outer_switch_select_out = boost_q[`BPCR_BIT_OUTER_SW];
	assign gate_drive_enable_out = boost_run_out & boost_q[`BPCR_BIT_OUTER_SW];
	assign adaptive_track_out = boost_q[`BPCR_BIT_ADAPT];
	assign boost_run_out = boost_q[`BPCR_BIT_BOOST_EN] & backlight_on_in;
	assign inductor_current_limit_out = boost_q[1:0];

	assign limit_code = boost_q[1:0];
	always @* begin
		limit_ma_d = `BPCR_LIMIT_0_MA;
		case (limit_code)
			2'b00: begin
				limit_ma_d = `BPCR_LIMIT_0_MA;
			end
			2'b01: begin
				limit_ma_d = `BPCR_LIMIT_1_MA;
			end
			2'b10: begin
				limit_ma_d = `BPCR_LIMIT_2_MA;
			end
			default: begin
				limit_ma_d = `BPCR_LIMIT_3_MA;
			end
		endcase
	end

	// registered so the limit moves one clean step per write
	always @(posedge ref_clk_in) begin
		if (srst_in) begin
			current_limit_ma_out <= `BPCR_LIMIT_0_MA;
		end else begin
			current_limit_ma_out <= limit_ma_d;
		end
	end

	assign low_supply_threshold_out = pwm_q[7:6];
	assign staggered_pwm_enable_out = pwm_q[`BPCR_BIT_STAGGER];
	assign output_rate_code_out = pwm_q[4:0];

	assign headroom_code = headroom_q[2:0];
	assign sink_headroom_setting_out = headroom_code;
	// Table instead of a multiplier; each code adds one 125 mV step
	always @* begin
		headroom_mv_d = `BPCR_HEADROOM_STEP_MV;
		case (headroom_code)
			3'b000: begin
				headroom_mv_d = `BPCR_HEADROOM_0_MV;
			end
			3'b001: begin
				headroom_mv_d = `BPCR_HEADROOM_1_MV;
			end
			3'b010: begin
				headroom_mv_d = `BPCR_HEADROOM_2_MV;
			end
			3'b011: begin
				headroom_mv_d = `BPCR_HEADROOM_3_MV;
			end
			3'b100: begin
				headroom_mv_d = `BPCR_HEADROOM_4_MV;
			end
			3'b101: begin
				headroom_mv_d = `BPCR_HEADROOM_5_MV;
			end
			3'b110: begin
				headroom_mv_d = `BPCR_HEADROOM_6_MV;
			end
			default: begin
				headroom_mv_d = `BPCR_HEADROOM_7_MV;
			end
		endcase
	end

	always @(posedge ref_clk_in) begin
		if (srst_in) begin
			headroom_mv_out <= `BPCR_HEADROOM_0_MV;
		end else begin
			headroom_mv_out <= headroom_mv_d;
		end
	end
endmodule

// One stored configuration byte; every bit kept exactly as written
module bpcr_byte_reg #(
	parameter [7:0] RST_VAL = 8'h00
) (
	input wire clk_in,
	input wire srst_in,
	input wire wr_in,
	input wire [7:0] wdata_in,
	output wire [7:0] value_out
);
	reg [7:0] value_q;

	always @(posedge clk_in) begin
		if (srst_in) begin
			value_q <= RST_VAL;
		end else if (wr_in) begin
			value_q <= wdata_in;
		end
	end
	assign value_out = value_q;
endmodule

// Adjust pacing divider: fires on every taken pulse, or on the last count when slow
module bpcr_pace_div #(
	parameter CNT_W = 4,
	parameter [CNT_W-1:0] LAST = {CNT_W{1'b1}}
) (
	input wire clk_in,
	input wire srst_in,
	input wire take_in,
	input wire slow_in,
	output wire [CNT_W-1:0] count_out,
	output wire fire_out
);
	reg [CNT_W-1:0] count_q;
	reg [CNT_W-1:0] count_d;
	reg fire_q;
	reg fire_d;

	always @* begin
		count_d = count_q;
		fire_d = 1'b0;
		if (take_in) begin
			if (!slow_in || count_q == LAST) begin
				fire_d = 1'b1;
				count_d = {CNT_W{1'b0}};
			end else begin
				count_d = count_q + {{(CNT_W-1){1'b0}}, 1'b1};
			end
		end
	end

	// Count clears on every adjust but holds while no pulse is taken, so slow pacing resumes a part-done round
	always @(posedge clk_in) begin
		if (srst_in) begin
			count_q <= {CNT_W{1'b0}};
			fire_q <= 1'b0;
		end else begin
			count_q <= count_d;
			fire_q <= fire_d;
		end
	end
	assign count_out = count_q;
	assign fire_out = fire_q;
endmodule

// ### pkg/bpcr_consts.vh
// Offsets, field positions, reset values and timing constants of the boost and PWM configuration registers
`ifndef BPCR_CONSTS_VH
`define BPCR_CONSTS_VH
`define BPCR_ADDR_W 8
`define BPCR_OFS_BOOST 8'hA2
`define BPCR_OFS_PWM 8'hA3
`define BPCR_OFS_HEADROOM 8'hA4
`define BPCR_OFS_STATUS 8'hB0
`define BPCR_RST_BOOST 8'h00
`define BPCR_RST_PWM 8'h00
`define BPCR_RST_HEADROOM 8'h00
`define BPCR_BIT_SLOW_ADJ 6
`define BPCR_BIT_LIGHT_LOAD 7
`define BPCR_BIT_SMOOTH 5
`define BPCR_BIT_OUTER_SW 4
`define BPCR_BIT_ADAPT 3
`define BPCR_BIT_BOOST_EN 2
`define BPCR_BIT_STAGGER 5
`define BPCR_SLOW_DIV 4'hF
`define BPCR_HEADROOM_STEP_MV 12'h07D
`define BPCR_HEADROOM_0_MV 12'h007D
`define BPCR_HEADROOM_1_MV 12'h00FA
`define BPCR_HEADROOM_2_MV 12'h0177
`define BPCR_HEADROOM_3_MV 12'h01F4
`define BPCR_HEADROOM_4_MV 12'h0271
`define BPCR_HEADROOM_5_MV 12'h02EE
`define BPCR_HEADROOM_6_MV 12'h036B
`define BPCR_HEADROOM_7_MV 12'h03E8
`define BPCR_LIMIT_0_MA 12'h0384
`define BPCR_LIMIT_1_MA 12'h0578
`define BPCR_LIMIT_2_MA 12'h07D0
`define BPCR_LIMIT_3_MA 12'h09C4
`endif

// ### verification/bpcr_chk.sv
// Assertion checker for the boost and PWM register bank
module bpcr_chk (
	input wire ref_clk_in, srst_in, wr_in, rd_in, pwm_cycle_in, backlight_on_in, boost_adjust_out,
	input wire outer_switch_select_out, gate_drive_enable_out, adaptive_track_out, boost_run_out,
	input wire staggered_pwm_enable_out,
	input wire [7:0] addr_in, wdata_in, rdata_out,
	input wire [1:0] inductor_current_limit_out, low_supply_threshold_out,
	input wire [4:0] output_rate_code_out,
	input wire [2:0] sink_headroom_setting_out,
	input wire [11:0] current_limit_ma_out, headroom_mv_out
);
default clocking @(posedge ref_clk_in); endclocking
default disable iff (srst_in);
localparam logic [11:0] LIM [4] = '{12'h0384, 12'h0578, 12'h07D0, 12'h09C4};
property p_pace; boost_adjust_out |-> $past(pwm_cycle_in && boost_run_out && adaptive_track_out); endproperty
a_pace: assert property (p_pace) else $error("pace");
property p_gate; gate_drive_enable_out == (outer_switch_select_out && boost_run_out); endproperty
a_gate: assert property (p_gate) else $error("gate");
property p_adapt; wr_in && addr_in == 8'hA2 |=> adaptive_track_out == $past(wdata_in[3]); endproperty
a_adapt: assert property (p_adapt) else $error("adapt");
property p_run; boost_run_out |-> backlight_on_in; endproperty
a_run: assert property (p_run) else $error("run");
property p_limit; current_limit_ma_out == LIM[$past(inductor_current_limit_out)]; endproperty
a_limit: assert property (p_limit) else $error("limit");
property p_stag; wr_in && addr_in == 8'hA3 |=> staggered_pwm_enable_out == $past(wdata_in[5]); endproperty
a_stag: assert property (p_stag) else $error("stagger");
property p_head; headroom_mv_out == 12'h007D * ({9'h000, $past(sink_headroom_setting_out)} + 12'h0001); endproperty
a_head: assert property (p_head) else $error("headroom");
property p_read; rd_in && addr_in == 8'hA3 |=>
	rdata_out == {low_supply_threshold_out, staggered_pwm_enable_out, output_rate_code_out}; endproperty
a_read: assert property (p_read) else $error("readback");
c_pace: cover property (boost_adjust_out);
c_gate: cover property (gate_drive_enable_out);
c_read: cover property (rd_in && addr_in == 8'hA3);
endmodule
bind bpcr_regs bpcr_chk u_bpcr_chk (.*);

// ### verification/testbench.sv
// Self-checking bench for the boost and PWM register bank
module testbench;
timeunit 1ns;
timeprecision 1ps;
logic ref_clk_in = 0, srst_in = 1, wr_in = 0, rd_in = 0, backlight_on_in = 0, pwm_cycle_in = 0;
logic [7:0] addr_in = '0, wdata_in = '0;
logic [11:0] lim [4] = '{12'h0384, 12'h0578, 12'h07D0, 12'h09C4};
wire [11:0] current_limit_ma_out, headroom_mv_out;
wire [7:0] rdata_out;
wire [4:0] output_rate_code_out;
wire [2:0] sink_headroom_setting_out;
wire [1:0] inductor_current_limit_out, low_supply_threshold_out;
wire boost_adjust_out, light_load_mode_out, smooth_ramp_enable_out, outer_switch_select_out;
wire gate_drive_enable_out, adaptive_track_out, boost_run_out, staggered_pwm_enable_out;
int error_cnt = 0, compares = 0, n;
bpcr_regs u_bpcr_regs (.*);
initial forever #2.5 ref_clk_in = ~ref_clk_in;
task automatic chk(string s, logic [11:0] seen, exp);
	compares++;
	if (seen !== exp) begin
		error_cnt++;
		$display("[FAIL] %s expected %h seen %h", s, exp, seen);
	end
endtask
task automatic wr(logic [7:0] a, d);
	@(posedge ref_clk_in) begin addr_in <= a; wdata_in <= d; wr_in <= 1; end
	@(posedge ref_clk_in) wr_in <= 0;
endtask
// Read data stands only in the cycle after the strobe
task automatic rd(logic [7:0] a, exp);
	@(posedge ref_clk_in) begin addr_in <= a; rd_in <= 1; end
	@(posedge ref_clk_in) rd_in <= 0;
	#1 chk("rdata", rdata_out, exp);
endtask
// Exactly k pulses are taken; the strobe drops at the edge that takes the last one
task automatic pulse(int k);
	n = 0;
	@(posedge ref_clk_in) pwm_cycle_in <= 1;
	for (int j = 1; j <= k; j++) begin
		@(posedge ref_clk_in) pwm_cycle_in <= (j < k);
		#1 n += int'(boost_adjust_out);
	end
endtask
task automatic t_regs;
	rd(8'hA2, 8'h00);
	wr(8'hA2, 8'hF0);
	rd(8'hA2, 8'hF0);
	chk("light", light_load_mode_out, 1);
	chk("smooth", smooth_ramp_enable_out, 1);
	wr(8'hA3, 8'hA5);
	rd(8'hA3, 8'hA5);
	chk("stagger", staggered_pwm_enable_out, 1);
	wr(8'h10, 8'hFF);
	rd(8'h10, 8'h00);
	for (int i = 0; i < 4; i++) begin
		wr(8'hA2, 8'(i));
		@(posedge ref_clk_in) #1 chk("limit", current_limit_ma_out, lim[i]);
	end
	for (int i = 0; i < 8; i++) begin
		wr(8'hA4, 8'(i));
		@(posedge ref_clk_in) #1 chk("headroom", headroom_mv_out, 12'(125 * (i + 1)));
	end
endtask
task automatic t_pace;
	wr(8'hA2, 8'h1C);
	@(posedge ref_clk_in) backlight_on_in <= 1;
	@(posedge ref_clk_in) #1 chk("gate", gate_drive_enable_out, 1);
	pulse(4);
	chk("fast", 12'(n), 4);
	wr(8'h5C, 8'h00);
	wr(8'hA2, 8'h4C);
	pulse(32);
	chk("slow", 12'(n), 2);
	rd(8'hB0, 8'h10);
	@(posedge ref_clk_in) backlight_on_in <= 0;
	@(posedge ref_clk_in) #1 chk("run", boost_run_out, 0);
endtask
task automatic finish_test;
	if (error_cnt == 0 && compares > 0) begin
		$display("RESULT: PASS");
	end else begin
		$display("RESULT: FAIL");
	end
	$finish;
endtask
initial begin
	#20000;
	error_cnt++;
	finish_test;
end
initial begin
	repeat (10) @(posedge ref_clk_in);
	srst_in <= 0;
	t_regs;
	t_pace;
	finish_test;
end
endmodule
